// ---- hw/lpdct_pkg.sv ----
package lpdct_pkg;

    // ----------------------------------------
    // clock and time figures
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_ADR_NS = 20;
    localparam int T_WLO_NS = 20;
    localparam int T_ODTD_NS = 12;
    localparam int T_ODTE_NS = 12;

    // longest times round down, never below one cycle
    localparam int ADR_CYC = (T_ADR_NS / CLK_PERIOD_NS < 1) ? 1 : T_ADR_NS / CLK_PERIOD_NS;
    localparam int WLO_CYC = (T_WLO_NS / CLK_PERIOD_NS < 1) ? 1 : T_WLO_NS / CLK_PERIOD_NS;
    localparam int ODTD_CYC = (T_ODTD_NS / CLK_PERIOD_NS < 1) ? 1 : T_ODTD_NS / CLK_PERIOD_NS;
    localparam int ODTE_CYC = (T_ODTE_NS / CLK_PERIOD_NS < 1) ? 1 : T_ODTE_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // latencies in link clocks
    // ----------------------------------------
    localparam logic [3:0] RL_HIGH = 4'hC;
    localparam logic [3:0] RL_LOW = 4'hA;
    localparam logic [3:0] WL_SET_A = 4'h6;
    localparam logic [3:0] WL_B_HIGH = 4'h9;
    localparam logic [3:0] WL_B_LOW = 4'h8;
    localparam int PIPE_LEN = 12;
    localparam int CA_WIDTH = 10;
    localparam int CMD_WIDTH = 4;
    localparam int SYNC_WIDTH = 2 + CMD_WIDTH + CA_WIDTH;

    // ----------------------------------------
    // command codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_MRW = 4'h1,
        CMD_MRR = 4'h2,
        CMD_ACTIVATE = 4'h3,
        CMD_READ = 4'h4,
        CMD_WRITE = 4'h5,
        CMD_PRECHARGE = 4'h6,
        CMD_REFRESH = 4'h7,
        CMD_PD_ENTER = 4'h8,
        CMD_SR_ENTER = 4'h9,
        CMD_DPD_ENTER = 4'hA,
        CMD_LP_EXIT = 4'hB,
        CMD_CAT_ENTER = 4'hC,
        CMD_CALIBRATE = 4'hD,
        CMD_WLEV_ENTER = 4'hE,
        CMD_MODE_EXIT = 4'hF
    } lpdct_cmd_t;

    // ----------------------------------------
    // device states
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PDOWN = 6'h02,
        ST_SREF = 6'h04,
        ST_DPD = 6'h08,
        ST_CATRAIN = 6'h10,
        ST_WLEV = 6'h20
    } lpdct_state_t;

endpackage : lpdct_pkg

// ---- hw/lpdct_pin_sync.sv ----
`timescale 1ns/1ns
module lpdct_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    // ----------------------------------------
    // two-flop synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign pinSync = stage2_reg;

endmodule : lpdct_pin_sync

// ---- hw/lpdct_device.sv ----
// Rules from the document; this block implements RULE5, RULE19, RULE21 and RULE22
// [RULE1] controller spaces mode writes ten clocks
// [RULE2] controller waits after mode write
// [RULE3] controller spaces mode reads four clocks
// [RULE4] controller waits extra before read after exit
// [RULE5] read latency twelve or ten; write per set
// [RULE6] controller keeps rows open within limits
// [RULE7] controller waits after precharge before activate
// [RULE8] controller waits after write before read
// [RULE9] controller waits between read and precharge
// [RULE10] controller spaces activates across banks
// [RULE11] at most four activates per window
// [RULE12] controller waits after self refresh exit
// [RULE13] controller waits after power-down exit
// [RULE14] clock enable low minimum in self refresh
// [RULE15] deep power-down held long enough
// [RULE16] command path disabled two clocks after
// [RULE17] boot clock period limited before configuration
// [RULE18] training step spacings for the controller
// [RULE19] calibration result driven within twenty ns
// [RULE20] controller spaces calibration commands
// [RULE21] leveling feedback within twenty ns of strobe
// [RULE22] termination off/on within twelve ns; the device switches it one clock (20 ns) after the state changes
// [RULE23] controller blocks commands until intervals expire
`timescale 1ns/1ns
module lpdct_device (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic clkEnable,
    input wire logic [lpdct_pkg::CMD_WIDTH-1:0] cmdIn,
    input wire logic [lpdct_pkg::CA_WIDTH-1:0] caIn,
    input wire logic strobeIn,
    input wire logic rateHigh,
    input wire logic writeSetB,
    output logic readDataValid,
    output logic writeDataCapture,
    output logic [lpdct_pkg::CA_WIDTH-1:0] dqOut,
    output logic dqOe,
    output logic odtEnable,
    output logic [5:0] deviceState
);

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    logic [lpdct_pkg::SYNC_WIDTH-1:0] syncBus;
    logic ckS;
    logic cke;
    logic strobeS;
    logic [lpdct_pkg::CMD_WIDTH-1:0] cmdS;
    logic [lpdct_pkg::CA_WIDTH-1:0] caS;

    lpdct_pin_sync #(.WIDTH(lpdct_pkg::SYNC_WIDTH + 1)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn({strobeIn, linkClk, clkEnable, cmdIn, caIn}),
        .pinSync({strobeS, syncBus})
    );

    assign {ckS, cke, cmdS, caS} = syncBus;

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    lpdct_pkg::lpdct_state_t state_reg, state_next;
    logic ckPrev_reg, ckPrev_next;
    logic strobePrev_reg, strobePrev_next;
    logic [lpdct_pkg::PIPE_LEN-1:0] readPipe_reg, readPipe_next;
    logic [lpdct_pkg::PIPE_LEN-1:0] writePipe_reg, writePipe_next;
    logic readDataValid_reg, readDataValid_next;
    logic writeDataCapture_reg, writeDataCapture_next;
    logic [lpdct_pkg::CA_WIDTH-1:0] dqOut_reg, dqOut_next;
    logic dqOe_reg, dqOe_next;
    logic odtEnable_reg, odtEnable_next;
    logic ckRise;
    logic strobeRise;
    logic [3:0] rlSel;
    logic [3:0] wlSel;
    logic lowPower;

    assign ckRise = ckS & ~ckPrev_reg;
    assign strobeRise = strobeS & ~strobePrev_reg;
    assign lowPower = (state_reg == lpdct_pkg::ST_PDOWN) || (state_reg == lpdct_pkg::ST_SREF)
                      || (state_reg == lpdct_pkg::ST_DPD);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        ckPrev_next = ckS;
        strobePrev_next = strobeS;
        readPipe_next = readPipe_reg;
        writePipe_next = writePipe_reg;
        readDataValid_next = readDataValid_reg;
        writeDataCapture_next = writeDataCapture_reg;
        dqOut_next = dqOut_reg;
        dqOe_next = dqOe_reg;
        odtEnable_next = ~lowPower; // RULE22
        rlSel = rateHigh ? lpdct_pkg::RL_HIGH : lpdct_pkg::RL_LOW; // RULE5
        wlSel = writeSetB ? (rateHigh ? lpdct_pkg::WL_B_HIGH : lpdct_pkg::WL_B_LOW)
                          : lpdct_pkg::WL_SET_A; // RULE5
        if (ckRise) begin
            readPipe_next = {readPipe_reg[lpdct_pkg::PIPE_LEN-2:0],
                             (state_reg == lpdct_pkg::ST_IDLE) && cke && (cmdS == lpdct_pkg::CMD_READ)};
            writePipe_next = {writePipe_reg[lpdct_pkg::PIPE_LEN-2:0],
                              (state_reg == lpdct_pkg::ST_IDLE) && cke && (cmdS == lpdct_pkg::CMD_WRITE)};
            readDataValid_next = readPipe_reg[rlSel - 4'h1]; // RULE5
            writeDataCapture_next = writePipe_reg[wlSel - 4'h1]; // RULE5
            unique case (state_reg)
                lpdct_pkg::ST_IDLE: begin
                    if (cke) begin
                        unique case (cmdS)
                            lpdct_pkg::CMD_PD_ENTER: state_next = lpdct_pkg::ST_PDOWN;
                            lpdct_pkg::CMD_SR_ENTER: state_next = lpdct_pkg::ST_SREF;
                            lpdct_pkg::CMD_DPD_ENTER: state_next = lpdct_pkg::ST_DPD;
                            lpdct_pkg::CMD_CAT_ENTER: state_next = lpdct_pkg::ST_CATRAIN;
                            lpdct_pkg::CMD_WLEV_ENTER: state_next = lpdct_pkg::ST_WLEV;
                            default: state_next = lpdct_pkg::ST_IDLE;
                        endcase
                    end
                end
                lpdct_pkg::ST_PDOWN, lpdct_pkg::ST_SREF, lpdct_pkg::ST_DPD: begin
                    if (cke && (cmdS == lpdct_pkg::CMD_LP_EXIT)) begin
                        state_next = lpdct_pkg::ST_IDLE;
                    end
                end
                lpdct_pkg::ST_CATRAIN: begin
                    if (cmdS == lpdct_pkg::CMD_CALIBRATE) begin
                        dqOut_next = caS; // RULE19
                        dqOe_next = 1'b1; // RULE19
                    end else if (cke && (cmdS == lpdct_pkg::CMD_MODE_EXIT)) begin
                        dqOe_next = 1'b0;
                        state_next = lpdct_pkg::ST_IDLE;
                    end
                end
                lpdct_pkg::ST_WLEV: begin
                    if (cmdS == lpdct_pkg::CMD_MODE_EXIT) begin
                        dqOe_next = 1'b0;
                        state_next = lpdct_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        // leveling: report sampled link clock at each strobe rise
        if ((state_reg == lpdct_pkg::ST_WLEV) && strobeRise) begin
            dqOut_next = {lpdct_pkg::CA_WIDTH{ckS}}; // RULE21
            dqOe_next = 1'b1; // RULE21
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= lpdct_pkg::ST_IDLE;
            ckPrev_reg <= 1'b0;
            strobePrev_reg <= 1'b0;
            readPipe_reg <= '0;
            writePipe_reg <= '0;
            readDataValid_reg <= 1'b0;
            writeDataCapture_reg <= 1'b0;
            dqOut_reg <= '0;
            dqOe_reg <= 1'b0;
            odtEnable_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            ckPrev_reg <= ckPrev_next;
            strobePrev_reg <= strobePrev_next;
            readPipe_reg <= readPipe_next;
            writePipe_reg <= writePipe_next;
            readDataValid_reg <= readDataValid_next;
            writeDataCapture_reg <= writeDataCapture_next;
            dqOut_reg <= dqOut_next;
            dqOe_reg <= dqOe_next;
            odtEnable_reg <= odtEnable_next;
        end
    end

    assign readDataValid = readDataValid_reg;
    assign writeDataCapture = writeDataCapture_reg;
    assign dqOut = dqOut_reg;
    assign dqOe = dqOe_reg;
    assign odtEnable = odtEnable_reg;
    assign deviceState = state_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence calib_taken_s;
        ckRise && (state_reg == lpdct_pkg::ST_CATRAIN) && (cmdS == lpdct_pkg::CMD_CALIBRATE);
    endsequence

    sequence strobe_lev_s;
        strobeRise && (state_reg == lpdct_pkg::ST_WLEV);
    endsequence

    calib_result_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE19
        calib_taken_s |-> ##[1:1] (dqOe && (dqOut == $past(caS))))
        else $error("calibration result late or wrong");

    lev_feedback_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
        strobe_lev_s |-> ##1 (dqOe && (dqOut[0] == $past(ckS))))
        else $error("leveling feedback late or wrong");

    odt_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE22
        lowPower |-> ##1 !odtEnable)
        else $error("termination not disabled in low power");

    odt_on_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE22
        $fell(lowPower) |-> ##1 odtEnable)
        else $error("termination not re-enabled after exit");

    read_latency_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
        $rose(readDataValid) |-> $past(ckRise) && $past(readPipe_reg[rlSel - 4'h1]))
        else $error("read data at wrong latency");

    write_latency_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
        (ckRise && writePipe_reg[wlSel - 4'h1]) |=> writeDataCapture)
        else $error("write capture at wrong latency");

endmodule : lpdct_device

// ---- dv/lpdct_ctrl_model.sv ----
`timescale 1ns/1ns
module lpdct_ctrl_model (
    input wire logic clk,
    output logic linkClk,
    output logic clkEnable,
    output logic [lpdct_pkg::CMD_WIDTH-1:0] cmdIn,
    output logic [lpdct_pkg::CA_WIDTH-1:0] caIn,
    output logic strobeIn
);
    // ----------------------------------------
    // free-running memory clock, own phase
    // ----------------------------------------
    initial begin
        linkClk = 1'b0;
        clkEnable = 1'b1;
        cmdIn = lpdct_pkg::CMD_NOP;
        caIn = 10'h155;
        strobeIn = 1'b0;
        #7;
        forever #80 linkClk = ~linkClk;
    end

    // ----------------------------------------
    // command, strobe and spacing helpers
    // ----------------------------------------
    // one command on one rise; bus inverted once released
    task automatic send(input lpdct_pkg::lpdct_cmd_t cmd, input logic [9:0] ca);
        @(negedge linkClk);
        @(posedge clk);
        cmdIn <= cmd;
        caIn <= ca;
        @(negedge linkClk);
        @(posedge clk);
        cmdIn <= lpdct_pkg::CMD_NOP;
        caIn <= ~ca;
    endtask : send

    // idle rises between commands
    task automatic idle(input int n);
        repeat (n) @(posedge linkClk);
    endtask : idle

    task automatic cke(input logic v);
        @(posedge clk);
        clkEnable <= v;
    endtask : cke

    task automatic strobe();
        @(posedge clk);
        strobeIn <= 1'b1;
        repeat (3) @(posedge clk);
        strobeIn <= 1'b0;
    endtask : strobe
endmodule : lpdct_ctrl_model

// ---- dv/lpdct_device_tb_top.sv ----
`timescale 1ns/1ns
module lpdct_device_tb_top;
    logic clk, reset_n, rateHigh, writeSetB, linkClk, clkEnable, strobeIn;
    logic [3:0] cmdIn;
    logic [9:0] caIn, dqOut;
    logic readDataValid, writeDataCapture, dqOe, odtEnable;
    logic [5:0] deviceState;
    int n_fail, n_tests;

    lpdct_device lpdct_device_inst (.clk(clk), .reset_n(reset_n), .linkClk(linkClk), .clkEnable(clkEnable),
        .cmdIn(cmdIn), .caIn(caIn), .strobeIn(strobeIn), .rateHigh(rateHigh), .writeSetB(writeSetB),
        .readDataValid(readDataValid), .writeDataCapture(writeDataCapture), .dqOut(dqOut), .dqOe(dqOe),
        .odtEnable(odtEnable), .deviceState(deviceState));
    lpdct_ctrl_model lpdct_ctrl_model_inst (.clk(clk), .linkClk(linkClk), .clkEnable(clkEnable),
        .cmdIn(cmdIn), .caIn(caIn), .strobeIn(strobeIn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic do_reset(input logic rate, input logic setB);
        @(posedge clk);
        reset_n <= 1'b0;
        rateHigh <= rate;
        writeSetB <= setB;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 check({odtEnable, dqOe, readDataValid, writeDataCapture, deviceState}, {4'b1000, 6'h01});
    endtask : do_reset

    // pulse must be absent after rise lat-1 and present after rise lat
    task automatic latency(input lpdct_pkg::lpdct_cmd_t cmd, input int lat);
        lpdct_ctrl_model_inst.send(cmd, 10'h000);
        repeat (lat - 1) @(posedge linkClk);
        #100 check(cmd == lpdct_pkg::CMD_READ ? readDataValid : writeDataCapture, 1'b0);
        @(posedge linkClk);
        #100 check(cmd == lpdct_pkg::CMD_READ ? readDataValid : writeDataCapture, 1'b1);
    endtask : latency

    task automatic lowpower();
        lpdct_pkg::lpdct_cmd_t ent [3] = '{lpdct_pkg::CMD_PD_ENTER, lpdct_pkg::CMD_SR_ENTER,
            lpdct_pkg::CMD_DPD_ENTER};
        logic [5:0] st [3] = '{6'h02, 6'h04, 6'h08};
        for (int i = 0; i < 3; i++) begin
            lpdct_ctrl_model_inst.send(ent[i], 10'h000);
            #40 check({odtEnable, deviceState}, {1'b0, st[i]});
            lpdct_ctrl_model_inst.cke(1'b0);
            lpdct_ctrl_model_inst.idle(2);
            lpdct_ctrl_model_inst.cke(1'b1);
            if (i < 2) begin
                lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_LP_EXIT, 10'h000);
                #40 check({odtEnable, deviceState}, 7'h41);
                lpdct_ctrl_model_inst.idle(2);
            end
        end
    endtask : lowpower

    task automatic training();
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_CAT_ENTER, 10'h000);
        lpdct_ctrl_model_inst.idle(20);
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_CALIBRATE, 10'h2A5);
        #40 check({dqOe, dqOut}, {1'b1, 10'h2A5});
        lpdct_ctrl_model_inst.idle(3);
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_CALIBRATE, 10'h15A);
        #40 check({dqOe, dqOut}, {1'b1, 10'h15A});
        lpdct_ctrl_model_inst.idle(10);
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_MODE_EXIT, 10'h000);
        #40 check({dqOe, deviceState}, 7'h01);
    endtask : training

    task automatic leveling();
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_WLEV_ENTER, 10'h000);
        lpdct_ctrl_model_inst.idle(1);
        #40 lpdct_ctrl_model_inst.strobe();
        #40 check({dqOe, dqOut}, {1'b1, 10'h3FF});
        @(negedge linkClk);
        #20 lpdct_ctrl_model_inst.strobe();
        #40 check({dqOe, dqOut}, {1'b1, 10'h000});
        lpdct_ctrl_model_inst.send(lpdct_pkg::CMD_MODE_EXIT, 10'h000);
        #40 check({dqOe, deviceState}, 7'h01);
    endtask : leveling

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        rateHigh = 1'b1;
        writeSetB = 1'b0;
        n_fail = 0;
        n_tests = 0;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[0], i[1]);
            latency(lpdct_pkg::CMD_READ, i[0] ? 12 : 10);
            latency(lpdct_pkg::CMD_WRITE, i[1] ? (i[0] ? 9 : 8) : 6);
        end
        lowpower();
        do_reset(1'b1, 1'b0);
        training();
        leveling();
        finish_test();
    end

    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule : lpdct_device_tb_top
